// *** shared/pin_select_map.svh ***
// register offsets, field positions, reset values and counts of the pin select block
`ifndef PIN_SELECT_MAP_SVH
`define PIN_SELECT_MAP_SVH

// byte offsets of the registers on the bus
`define OFF_GLOBAL_CFG 12'h000
`define OFF_CFG_ONE_A 12'h004
`define OFF_CFG_ONE_B 12'h008
`define OFF_CFG_TWO 12'h00c
`define OFF_CFG_INFRARED 12'h010
`define OFF_CFG_IRQ_GROUP 12'h014
`define OFF_CFG_FAN_CHASSIS 12'h018

// reset value of every select register
`define RST_CFG 8'h00

// field positions
`define POS_GLOBAL_IRQ 6
`define POS_PIN1_LO 0
`define POS_PIN25_LO 1
`define POS_PIN26 3
`define POS_PIN27_LO 4
`define POS_STBY 7
`define POS_PIN24 0
`define POS_PIN28 6
`define POS_PIN69_LO 0
`define POS_PIN71_LO 2
`define POS_PIN127_LO 6
`define POS_PIN128_LO 0

// edges after reset release before straps are taken
`define STRAP_WAIT 2'h2

`endif

// *** shared/pin_select_pkg.sv ***
// types of the pin select block
package pin_select_pkg;

  // bus answer states
  typedef enum logic [1:0] {
    APB_IDLE = 2'b01,
    APB_DONE = 2'b10
  } apb_st_t;

  // whole state of the block
  typedef struct packed {
    apb_st_t apb;
    logic [7:0] glob;
    logic [7:0] one_a;
    logic [7:0] one_b;
    logic [7:0] two;
    logic [7:0] infra;
    logic [7:0] irqg;
    logic [7:0] fanc;
    logic [1:0] strap_s1;
    logic [1:0] strap_s2;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [1:0] pin1_sel;
    logic [5:0] pin2_7_alt;
    logic [1:0] pin8_9_kbd;
    logic pin21_alt;
    logic [4:0] pin53_57_alt;
    logic [1:0] pin58_59_alt;
    logic pin24_alt;
    logic [1:0] pin25_sel;
    logic pin26_alt;
    logic [1:0] pin27_sel;
    logic pin28_alt;
    logic stby_alt;
    logic [1:0] pin69_sel;
    logic [1:0] pin71_sel;
    logic irq_117_124;
    logic irq_125_126;
    logic [1:0] pin127_sel;
    logic [1:0] pin128_sel;
  } state_t;

endpackage

// *** rtl/multifunction_pin_select.sv ***
// register-controlled pin multiplexer with apb register access
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_map.svh"

// Behaviour
// - pin 1 picks gpio, fan pwm, lock
// - pin 25 picks gpio, led 1, overtemp 2
// - pin 26 picks gpio or led 2
// - pin 27 picks gpio, ring wake, alarm
// - one bit switches standby pins 33-37
// - pin 69 picks gpio, motor, infrared 2
// - pin 71 picks gpio, drive select, infrared 3
// - global bit makes pins 117-124 interrupts
// - global bit makes pins 125-126 interrupts
// - pin 127 decodes two bits plus global
// - pin 128 picks gpio, tach, unlock
// - global bit overrides pins 117-127 fields
// - straps give initial selection after power-up
module multifunction_pin_select #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // strap pins
  input wire logic pin_select_strap_0,
  input wire logic pin_select_strap_1,
  // pin function selects
  output logic [1:0] pin1_sel,
  output logic [5:0] pin2_7_alt,
  output logic [1:0] pin8_9_kbd,
  output logic pin21_alt,
  output logic [4:0] pin53_57_alt,
  output logic [1:0] pin58_59_alt,
  output logic pin24_alt,
  output logic [1:0] pin25_sel,
  output logic pin26_alt,
  output logic [1:0] pin27_sel,
  output logic pin28_alt,
  output logic stby_alt,
  output logic [1:0] pin69_sel,
  output logic [1:0] pin71_sel,
  output logic irq_117_124,
  output logic irq_125_126,
  output logic [1:0] pin127_sel,
  output logic [1:0] pin128_sel
);
  import pin_select_pkg::*;

  state_t st_r; // registered state
  state_t st_nxt; // next state

  // three-way field: the unlisted code 11 falls back to gpio
  function automatic logic [1:0] dec3(input logic [1:0] f);
    dec3 = (f == 2'b11) ? 2'b00 : f;
  endfunction

  // address decode: bit 3 valid, bits 2-0 register index
  function automatic logic [3:0] addr_dec(input logic [ADDR_W-1:0] a);
    unique case (a[11:0])
      `OFF_GLOBAL_CFG: addr_dec = 4'h8;
      `OFF_CFG_ONE_A: addr_dec = 4'h9;
      `OFF_CFG_ONE_B: addr_dec = 4'ha;
      `OFF_CFG_TWO: addr_dec = 4'hb;
      `OFF_CFG_INFRARED: addr_dec = 4'hc;
      `OFF_CFG_IRQ_GROUP: addr_dec = 4'hd;
      `OFF_CFG_FAN_CHASSIS: addr_dec = 4'he;
      default: addr_dec = 4'h0;
    endcase
  endfunction

  // next state
  always_comb
  begin
    logic [3:0] hit;
    logic glob_irq;
    hit = addr_dec(paddr);
    glob_irq = 1'b0;
    st_nxt = st_r;
    // strap synchroniser, first stage feeds second only
    st_nxt.strap_s1 = {pin_select_strap_1, pin_select_strap_0};
    st_nxt.strap_s2 = st_r.strap_s1;
    // apb answer: one wait cycle, then pready for one cycle
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;
    unique case (st_r.apb)
      APB_IDLE:
      begin
        if (psel && penable)
        begin
          st_nxt.apb = APB_DONE;
          st_nxt.pready = 1'b1;
          st_nxt.pslverr = ~hit[3];
          st_nxt.prdata = 32'h0000_0000;
          // read data, upper bits zero
          if (!pwrite)
          begin
            unique case (hit)
              4'h8: st_nxt.prdata[7:0] = st_r.glob;
              4'h9: st_nxt.prdata[7:0] = st_r.one_a;
              4'ha: st_nxt.prdata[7:0] = st_r.one_b;
              4'hb: st_nxt.prdata[7:0] = st_r.two;
              4'hc: st_nxt.prdata[7:0] = st_r.infra;
              4'hd: st_nxt.prdata[7:0] = st_r.irqg;
              4'he: st_nxt.prdata[7:0] = st_r.fanc;
              default: st_nxt.prdata[7:0] = 8'h00;
            endcase
          end
        end
      end
      APB_DONE:
      begin
        st_nxt.apb = APB_IDLE;
        // write lands at the edge that samples pready high
        if (psel && penable && pwrite && pstrb[0])
        begin
          unique case (hit)
            4'h8: st_nxt.glob = pwdata[7:0];
            4'h9: st_nxt.one_a = pwdata[7:0];
            4'ha: st_nxt.one_b = pwdata[7:0];
            4'hb: st_nxt.two = pwdata[7:0];
            4'hc: st_nxt.infra = pwdata[7:0];
            4'hd: st_nxt.irqg = pwdata[7:0];
            4'he: st_nxt.fanc = pwdata[7:0];
            default: st_nxt.glob = st_r.glob;
          endcase
        end
      end
      default: st_nxt.apb = APB_IDLE;
    endcase
    // straps are taken once, after they have settled
    if (!st_r.strap_done)
    begin
      if (st_r.strap_cnt == `STRAP_WAIT)
      begin
        st_nxt.strap_done = 1'b1;
        st_nxt.two[`POS_PIN25_LO+1:`POS_PIN25_LO] = {1'b0, st_r.strap_s2[0]};
        st_nxt.two[`POS_PIN26] = st_r.strap_s2[0];
        st_nxt.two[`POS_STBY] = st_r.strap_s2[1];
      end
      else
      begin
        st_nxt.strap_cnt = st_r.strap_cnt + 2'h1;
      end
    end
    // pin routing from the current field values
    glob_irq = st_r.glob[`POS_GLOBAL_IRQ];
    st_nxt.pin1_sel = dec3(st_r.one_a[`POS_PIN1_LO+1:`POS_PIN1_LO]);
    st_nxt.pin2_7_alt = st_r.one_a[7:2];
    st_nxt.pin8_9_kbd = st_r.one_b[1:0];
    st_nxt.pin21_alt = st_r.one_b[2];
    st_nxt.pin53_57_alt = {st_r.one_b[7:5], st_r.one_b[5:4]};
    st_nxt.pin58_59_alt = st_r.infra[1:0];
    st_nxt.pin24_alt = st_r.two[`POS_PIN24];
    st_nxt.pin28_alt = st_r.two[`POS_PIN28];
    st_nxt.pin25_sel = dec3(st_r.two[`POS_PIN25_LO+1:`POS_PIN25_LO]);
    st_nxt.pin26_alt = st_r.two[`POS_PIN26];
    st_nxt.pin27_sel = dec3(st_r.two[`POS_PIN27_LO+1:`POS_PIN27_LO]);
    st_nxt.stby_alt = st_r.two[`POS_STBY];
    st_nxt.pin69_sel = dec3(st_r.irqg[`POS_PIN69_LO+1:`POS_PIN69_LO]);
    st_nxt.pin71_sel = dec3(st_r.irqg[`POS_PIN71_LO+1:`POS_PIN71_LO]);
    // the local bit alone is an unlisted code and keeps gpio
    st_nxt.irq_117_124 = glob_irq;
    st_nxt.irq_125_126 = glob_irq;
    // pin 127: global bit first, then 00 gpio, 01 keyboard, 10 infrared
    if (glob_irq)
    begin
      st_nxt.pin127_sel = 2'h3;
    end
    else
    begin
      st_nxt.pin127_sel = dec3(st_r.irqg[`POS_PIN127_LO+1:`POS_PIN127_LO]);
    end
    // pin 128: 10 tach, 11 unlock, others gpio
    unique case (st_r.fanc[`POS_PIN128_LO+1:`POS_PIN128_LO])
      2'b10: st_nxt.pin128_sel = 2'h1;
      2'b11: st_nxt.pin128_sel = 2'h2;
      default: st_nxt.pin128_sel = 2'h0;
    endcase
  end

  // state register
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r <= '0;
      st_r.apb <= APB_IDLE;
      st_r.glob <= `RST_CFG;
      st_r.one_a <= `RST_CFG;
      st_r.one_b <= `RST_CFG;
      st_r.two <= `RST_CFG;
      st_r.infra <= `RST_CFG;
      st_r.irqg <= `RST_CFG;
      st_r.fanc <= `RST_CFG;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign pin1_sel = st_r.pin1_sel;
  assign pin2_7_alt = st_r.pin2_7_alt;
  assign pin8_9_kbd = st_r.pin8_9_kbd;
  assign pin21_alt = st_r.pin21_alt;
  assign pin53_57_alt = st_r.pin53_57_alt;
  assign pin58_59_alt = st_r.pin58_59_alt;
  assign pin24_alt = st_r.pin24_alt;
  assign pin25_sel = st_r.pin25_sel;
  assign pin26_alt = st_r.pin26_alt;
  assign pin27_sel = st_r.pin27_sel;
  assign pin28_alt = st_r.pin28_alt;
  assign stby_alt = st_r.stby_alt;
  assign pin69_sel = st_r.pin69_sel;
  assign pin71_sel = st_r.pin71_sel;
  assign irq_117_124 = st_r.irq_117_124;
  assign irq_125_126 = st_r.irq_125_126;
  assign pin127_sel = st_r.pin127_sel;
  assign pin128_sel = st_r.pin128_sel;

  // checks on the routing and the bus answer
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  AST_PIN1: assert property (##1 pin1_sel == dec3($past(st_r.one_a[1:0])))
    else $error("pin 1 select wrong");
  AST_PIN25: assert property ($past(st_r.two[2:1]) == 2'b01 |-> pin25_sel == 2'h1)
    else $error("pin 25 led select wrong");
  AST_PIN26: assert property (##1 pin26_alt == $past(st_r.two[3]))
    else $error("pin 26 select wrong");
  AST_PIN27: assert property ($past(st_r.two[5:4]) == 2'b10 |-> pin27_sel == 2'h2)
    else $error("pin 27 alarm select wrong");
  AST_STBY: assert property ($rose(st_r.two[7]) |=> stby_alt)
    else $error("standby group did not follow");
  AST_PIN69: assert property (##1 pin69_sel == dec3($past(st_r.irqg[1:0])))
    else $error("pin 69 select wrong");
  AST_PIN71: assert property ($past(st_r.irqg[3:2]) == 2'b10 |-> pin71_sel == 2'h2)
    else $error("pin 71 infrared select wrong");
  AST_IRQ8: assert property (st_r.glob[6] |=> irq_117_124)
    else $error("pins 117-124 not forced to interrupt");
  AST_IRQ2: assert property (!st_r.glob[6] |=> !irq_125_126)
    else $error("pins 125-126 interrupt without global bit");
  AST_PIN127: assert property (!st_r.glob[6] && st_r.irqg[7:6] == 2'b01
    |=> pin127_sel == 2'h1)
    else $error("pin 127 keyboard select wrong");
  AST_PIN127_IR: assert property (!st_r.glob[6] && st_r.irqg[7:6] == 2'b10
    |=> pin127_sel == 2'h2)
    else $error("pin 127 infrared select wrong");
  AST_PIN128: assert property (st_r.fanc[1:0] == 2'b01 |=> pin128_sel == 2'h0)
    else $error("pin 128 unlisted code not gpio");
  AST_PIN128_TACH: assert property (st_r.fanc[1:0] == 2'b10 |=> pin128_sel == 2'h1)
    else $error("pin 128 tach select wrong");
  AST_GLOB: assert property (st_r.glob[6] && st_r.irqg[7:6] == 2'b10
    |=> pin127_sel == 2'h3)
    else $error("global bit did not override pin 127");
  AST_IRQ8_OFF: assert property (!st_r.glob[6] |=> !irq_117_124)
    else $error("pins 117-124 interrupt without global bit");
  AST_IRQ2_ON: assert property (st_r.glob[6] |=> irq_125_126)
    else $error("pins 125-126 not forced to interrupt");
  AST_STRAP: assert property ($rose(st_r.strap_done)
    |-> st_r.two[7] == $past(st_r.strap_s2[1]))
    else $error("strap not taken into standby select");
  AST_KBD: assert property (##1 pin8_9_kbd == $past(st_r.one_b[1:0]))
    else $error("pins 8-9 select wrong");
  AST_FALLBACK: assert property (pin71_sel != 2'h3 && pin1_sel != 2'h3)
    else $error("unlisted code reached an output");
  AST_PREADY: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("pready not a one-cycle answer");
  // a refused write leaves glob, one_a, one_b, infra, irqg and fanc as they were; two is not checked
  AST_REFUSE: assert property (psel && penable && pready && (pslverr || (pwrite && !pstrb[0]))
    |=> $stable({st_r.glob, st_r.one_a, st_r.one_b, st_r.infra, st_r.irqg, st_r.fanc}))
    else $error("refused write changed a register");
  // an accepted write to fanc is held in the register from the next edge on
  AST_WR_LAND: assert property (psel && penable && pready && pwrite && pstrb[0]
    && paddr == `OFF_CFG_FAN_CHASSIS |=> st_r.fanc == $past(pwdata[7:0]))
    else $error("write did not land");

  COV_WRITE: cover property (psel && penable && pready && pwrite);
  COV_READ: cover property (psel && penable && pready && !pwrite);
  COV_SLVERR: cover property (pready && pslverr);
  COV_IRQ: cover property ($rose(irq_117_124));
  COV_STRAP: cover property ($rose(st_r.strap_done));

endmodule
`default_nettype wire

// *** testbench/strap_board.sv ***
// board straps seen by the pin select block from power-up on
`timescale 1ns/1ps
`default_nettype none
module strap_board #(
  parameter logic STRAP_0 = 1'b1,
  parameter logic STRAP_1 = 1'b1
) (
  // strap levels towards the device
  output logic pin_select_strap_0,
  output logic pin_select_strap_1
);
  // resistor straps hold one level, so no edge to synchronise
  assign pin_select_strap_0 = STRAP_0;
  assign pin_select_strap_1 = STRAP_1;
endmodule
`default_nettype wire

// *** testbench/multifunction_pin_select_bench.sv ***
// self-checking bench of the pin select block over apb
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_map.svh"
module multifunction_pin_select_bench;
  import pin_select_pkg::*;
  logic ref_clk = 1'b0; // bus clock
  logic reset_n = 1'b0; // reset, active low
  logic psel = 1'b0; // apb request
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready, pslverr;
  wire logic s0, s1; // strap wires
  logic [1:0] pin1_sel, pin8_9_kbd, pin58_59_alt, pin25_sel, pin27_sel;
  logic [1:0] pin69_sel, pin71_sel, pin127_sel, pin128_sel;
  logic [5:0] pin2_7_alt;
  logic [4:0] pin53_57_alt;
  logic pin21_alt, pin24_alt, pin26_alt, pin28_alt, stby_alt, irq_117_124, irq_125_126;
  int err_count = 0; // mismatches
  int n_tests = 0; // comparisons
  int cycles = 0; // hang guard
  logic [31:0] rdv; // last read data
  logic errv; // last error answer
  logic [1:0] f, g; // expected selects
  logic [11:0] offs [6] = '{`OFF_GLOBAL_CFG, `OFF_CFG_ONE_A, `OFF_CFG_ONE_B,
    `OFF_CFG_INFRARED, `OFF_CFG_IRQ_GROUP, `OFF_CFG_FAN_CHASSIS};

  // free-running clock
  always #20 ref_clk = ~ref_clk;

  // straps differ, so a swapped strap mapping shows up
  strap_board #(.STRAP_0(1'b1), .STRAP_1(1'b0)) board_u (.pin_select_strap_0(s0),
    .pin_select_strap_1(s1));

  multifunction_pin_select dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_select_strap_0(s0),
    .pin_select_strap_1(s1), .pin1_sel(pin1_sel), .pin2_7_alt(pin2_7_alt),
    .pin8_9_kbd(pin8_9_kbd), .pin21_alt(pin21_alt), .pin53_57_alt(pin53_57_alt),
    .pin58_59_alt(pin58_59_alt), .pin24_alt(pin24_alt), .pin25_sel(pin25_sel),
    .pin26_alt(pin26_alt), .pin27_sel(pin27_sel), .pin28_alt(pin28_alt),
    .stby_alt(stby_alt), .pin69_sel(pin69_sel), .pin71_sel(pin71_sel),
    .irq_117_124(irq_117_124), .irq_125_126(irq_125_126), .pin127_sel(pin127_sel),
    .pin128_sel(pin128_sel));

  // verdict and end of run
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // compare seen against expected
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one apb transfer, held until pready, then two edges for the selects
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1)
      @(posedge ref_clk);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  // read and compare
  task automatic rd(input string name, input logic [11:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    chk(name, rdv, exp);
  endtask

  // hang guard
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      err_count++;
      conclude();
    end
  end

  // main sequence
  initial
  begin
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd("cfg_two strap", `OFF_CFG_TWO, 32'h0a);
    chk("cfg_two err", errv, 1'h0);
    chk("pin25 strap", pin25_sel, 2'h1);
    chk("pin26 strap", pin26_alt, 1'h1);
    chk("standby strap", stby_alt, 1'h0);
    foreach (offs[i])
      rd("reset value", offs[i], 32'h0);
    // every code of the multi-bit fields
    for (int c = 0; c < 4; c++)
    begin
      f = (c == 3) ? 2'h0 : 2'(c);
      g = (c == 2) ? 2'h1 : ((c == 3) ? 2'h2 : 2'h0);
      apb(1'b1, `OFF_CFG_ONE_A, 32'(c));
      chk("pin1", pin1_sel, f);
      apb(1'b1, `OFF_CFG_TWO, 32'(c * 18));
      chk("pin25", pin25_sel, f);
      chk("pin27", pin27_sel, f);
      rd("cfg_two back", `OFF_CFG_TWO, 32'(c * 18));
      apb(1'b1, `OFF_CFG_IRQ_GROUP, 32'(c * 69));
      chk("pin69", pin69_sel, f);
      chk("pin71", pin71_sel, f);
      chk("pin127", pin127_sel, f);
      apb(1'b1, `OFF_CFG_FAN_CHASSIS, 32'(c));
      chk("pin128", pin128_sel, g);
    end
    // local interrupt bits alone, then the global override
    apb(1'b1, `OFF_CFG_IRQ_GROUP, 32'hb0);
    chk("pin127 infrared", pin127_sel, 2'h2);
    chk("irq low alone", irq_117_124, 1'h0);
    chk("irq high alone", irq_125_126, 1'h0);
    apb(1'b1, `OFF_GLOBAL_CFG, 32'h40);
    chk("irq low global", irq_117_124, 1'h1);
    chk("irq high global", irq_125_126, 1'h1);
    chk("pin127 global", pin127_sel, 2'h3);
    apb(1'b1, `OFF_GLOBAL_CFG, 32'h0);
    chk("pin127 released", pin127_sel, 2'h2);
    // single-bit selects; one_b bit 5 drives two of pins 53-57
    apb(1'b1, `OFF_CFG_ONE_A, 32'hfc);
    chk("pins 2-7", pin2_7_alt, 6'h3f);
    chk("pin1 kept", pin1_sel, 2'h0);
    apb(1'b1, `OFF_CFG_ONE_B, 32'hf4);
    chk("kbd off", pin8_9_kbd, 2'h0);
    chk("pin21", pin21_alt, 1'h1);
    chk("pins 53-57", pin53_57_alt, 5'h1f);
    apb(1'b1, `OFF_CFG_ONE_B, 32'h03);
    chk("kbd kept", pin8_9_kbd, 2'h3);
    chk("pins 53-57 off", pin53_57_alt, 5'h00);
    apb(1'b1, `OFF_CFG_INFRARED, 32'h02);
    chk("pins 58-59", pin58_59_alt, 2'h2);
    apb(1'b1, `OFF_CFG_TWO, 32'h88);
    chk("pin26 set", pin26_alt, 1'h1);
    chk("standby set", stby_alt, 1'h1);
    chk("pin25 gpio", pin25_sel, 2'h0);
    apb(1'b1, `OFF_CFG_TWO, 32'h41);
    chk("pin24", pin24_alt, 1'h1);
    chk("pin28", pin28_alt, 1'h1);
    chk("pin26 clear", pin26_alt, 1'h0);
    chk("standby clear", stby_alt, 1'h0);
    // refusals: unmapped place and missing strobe
    apb(1'b1, 12'h020, 32'hff);
    chk("unmapped write err", errv, 1'h1);
    rd("unmapped read", 12'h020, 32'h0);
    chk("unmapped read err", errv, 1'h1);
    pstrb <= 4'h0;
    apb(1'b1, `OFF_CFG_ONE_A, 32'h01);
    pstrb <= 4'hf;
    rd("no strobe", `OFF_CFG_ONE_A, 32'hfc);
    chk("pin1 no strobe", pin1_sel, 2'h0);
    conclude();
  end
endmodule
`default_nettype wire
